/* rtl/pdec_entry_ctrl.sv */
// Purpose: decides whether a power-down instruction enters power-down mode
// Assumes: CPU core pulses power_down_instruction for one cycle on execution
// Notes: models the quasi-idle state that traps external fetches
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Select clear and interrupt pin high: power-down instruction is ignored.
// - Select set and any enabled wake pin active: instruction is ignored.
// - Otherwise the instruction enters power-down mode normally.
// - External next code, multiplexed bus, tristate wait bit 0: enter quasi-idle.
// - Prior external write plus external next code: quasi-idle for any bus.
// - Peripherals and watchdog keep running; watchdog overflow resets the device.
// - Quasi-idle services no interrupts and no event transfers.
// - Interrupt pin driven low while quasi-idle moves into power-down.
// - External reset always leaves interruptible power-down.
module pdec_entry_ctrl
  import pdec_pkg::*;
#(
  parameter int WAKE_PINS = PDEC_WAKE_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // CPU core side
  input wire logic power_down_instruction,
  input wire logic prev_ext_write,
  input wire logic next_code_external,
  input wire logic wake_source_select,
  input wire logic mux_bus_cfg,
  input wire logic mem_tristate_wait_ctrl,
  // Pins
  input wire logic nmi_pin,
  input wire logic [WAKE_PINS-1:0] wake_pins,
  input wire logic [WAKE_PINS-1:0] wake_pin_enable,
  input wire logic [WAKE_PINS-1:0] wake_pin_active_high,
  input wire logic ext_interrupt_wake,
  // Watchdog
  input wire logic watchdog_overflow,
  input wire logic watchdog_disabled,
  // Status and control out
  output logic power_down_active,
  output logic quasi_idle_active,
  output logic fetch_stall,
  output logic irq_service_block,
  output logic event_transfer_channel_block,
  output logic peripherals_run,
  output logic watchdog_reset_req,
  output logic instr_ignored
);
  localparam int SW = WAKE_PINS + 1;

  typedef struct packed {
    pdec_state_t state;
    logic ignored;
    logic wdt_rst;
  } pdec_st_t;

  pdec_st_t st_reg;
  pdec_st_t st_next;

  pdec_sync_if #(.W(SW)) pins ();

  // Pins cross in from outside through two flops
  assign pins.raw = {nmi_pin, wake_pins};

  pdec_pin_sync #(.W(SW)) u_sync (
    .clk(clk),
    .reset(reset),
    .pins(pins)
  );

  logic nmi_s;
  logic [WAKE_PINS-1:0] wake_s;
  assign nmi_s = pins.synced[WAKE_PINS];
  assign wake_s = pins.synced[WAKE_PINS-1:0];

  // Any enabled wake pin at its active level
  function automatic logic wake_any(input logic [WAKE_PINS-1:0] lvl,
                                    input logic [WAKE_PINS-1:0] en,
                                    input logic [WAKE_PINS-1:0] pol);
    wake_any = |(en & ~(lvl ^ pol));
  endfunction

  logic block_entry;
  logic quasi_cond;

  // Decision uses synchronised levels, two clocks behind the pins
  always_comb begin
    if (wake_source_select) begin
      block_entry = wake_any(wake_s, wake_pin_enable, wake_pin_active_high);
    end else begin
      block_entry = nmi_s;
    end
    quasi_cond = next_code_external &
                 ((mux_bus_cfg & (mem_tristate_wait_ctrl == 1'b0)) | prev_ext_write);
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.ignored = 1'b0;
    st_next.wdt_rst = 1'b0;
    case (st_reg.state)
      PDEC_RUN: begin
        if (power_down_instruction) begin
          if (block_entry && quasi_cond) begin
            // Blocked but the fetch unit is already stopped
            st_next.state = PDEC_QUASI_IDLE;
          end else if (block_entry) begin
            st_next.ignored = 1'b1;
          end else begin
            st_next.state = PDEC_POWER_DOWN;
          end
        end
      end
      PDEC_QUASI_IDLE: begin
        if (watchdog_overflow && !watchdog_disabled) begin
          st_next.wdt_rst = 1'b1;
          st_next.state = PDEC_RUN;
        end else if (!nmi_s) begin
          st_next.state = PDEC_POWER_DOWN;
        end
      end
      PDEC_POWER_DOWN: begin
        // Interrupt wake; clock limit is left to the system
        if (ext_interrupt_wake) begin
          st_next.state = PDEC_RUN;
        end
      end
      default: begin
        st_next.state = PDEC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{state: PDEC_RUN, ignored: PDEC_RST_LEVEL, wdt_rst: PDEC_RST_LEVEL};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs decoded from registered state
  assign power_down_active = (st_reg.state == PDEC_POWER_DOWN);
  assign quasi_idle_active = (st_reg.state == PDEC_QUASI_IDLE);
  assign fetch_stall = (st_reg.state != PDEC_RUN);
  assign irq_service_block = quasi_idle_active;
  assign event_transfer_channel_block = quasi_idle_active;
  assign peripherals_run = (st_reg.state != PDEC_POWER_DOWN);
  assign watchdog_reset_req = st_reg.wdt_rst;
  assign instr_ignored = st_reg.ignored;

  a_nmi_blocks_entry: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == PDEC_RUN && power_down_instruction && !wake_source_select
     && nmi_s && !quasi_cond) |=> (instr_ignored && !power_down_active))
    else $error("entry not ignored with interrupt pin high");

  a_wake_blocks_entry: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == PDEC_RUN && power_down_instruction && wake_source_select
     && wake_any(wake_s, wake_pin_enable, wake_pin_active_high) && !quasi_cond)
    |=> (instr_ignored && st_reg.state == PDEC_RUN))
    else $error("entry not ignored with wake pin active");

  a_normal_entry: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == PDEC_RUN && power_down_instruction && !block_entry)
    |=> power_down_active && !instr_ignored)
    else $error("normal power-down entry missed");

  a_tristate_quasi: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == PDEC_RUN && power_down_instruction && block_entry
     && next_code_external && mux_bus_cfg && !mem_tristate_wait_ctrl)
    |=> quasi_idle_active && fetch_stall)
    else $error("quasi-idle not entered for tristate wait case");

  a_write_quasi: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == PDEC_RUN && power_down_instruction && block_entry
     && next_code_external && prev_ext_write) |=> quasi_idle_active)
    else $error("quasi-idle not entered after external write");

  a_wdt_in_quasi: assert property (@(posedge clk) disable iff (reset)
    (quasi_idle_active && watchdog_overflow && !watchdog_disabled)
    |=> watchdog_reset_req ##1 !watchdog_reset_req)
    else $error("watchdog reset not raised for one cycle");

  a_quasi_blocks_irq: assert property (@(posedge clk) disable iff (reset)
    quasi_idle_active |-> irq_service_block && event_transfer_channel_block
    && peripherals_run)
    else $error("interrupt or transfer not blocked in quasi-idle");

  // quasi-idle only from a trapped instruction
  a_quasi_from_trap: assert property (@(posedge clk) disable iff (reset)
    $rose(quasi_idle_active) |-> $past(power_down_instruction && block_entry && quasi_cond))
    else $error("quasi-idle entered without a trapped instruction");

  // low interrupt pin leads to power-down
  a_quasi_to_pd: assert property (@(posedge clk) disable iff (reset)
    (quasi_idle_active && !nmi_s && !(watchdog_overflow && !watchdog_disabled))
    |=> power_down_active)
    else $error("quasi-idle did not proceed to power-down");

  a_reset_exits: assert property (@(posedge clk)
    reset |=> !power_down_active && !quasi_idle_active)
    else $error("reset did not leave power-down");
endmodule
`default_nettype wire

/* rtl/pdec_pin_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: pins are quasi-static relative to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module pdec_pin_sync
  import pdec_pkg::*;
#(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin carrier
  pdec_sync_if.sync pins
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pdec_sync_st_t;

  pdec_sync_st_t st_reg;
  pdec_sync_st_t st_next;

  // Shift the raw levels through two stages
  always_comb begin
    st_next = st_reg;
    st_next.meta = pins.raw;
    st_next.stable = st_reg.meta;
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.synced = st_reg.stable;
endmodule
`default_nettype wire

/* shared/pdec_pkg.sv */
// Purpose: constants and types for the power-down entry control block
// Assumes: single clock domain, synchronous active-high reset
// Notes: wake pin count is a parameter of the top module
package pdec_pkg;
  // Reset values
  localparam logic PDEC_RST_LEVEL = 1'b0;
  // Synchroniser depth for pin inputs
  localparam int PDEC_SYNC_STAGES = 2;
  // Default number of wake-up port pins
  localparam int PDEC_WAKE_PINS = 16;
  // Cycles the instruction-pending request is held before a decision
  localparam logic [1:0] PDEC_DECIDE_LAT = 2'h1;

  // Operating states
  typedef enum logic [1:0] {
    PDEC_RUN,
    PDEC_QUASI_IDLE,
    PDEC_POWER_DOWN
  } pdec_state_t;
endpackage

/* shared/pdec_sync_if.sv */
// Purpose: carrier between top and the pin synchroniser
// Assumes: one clock
// Notes: raw pin levels in, synchronised levels out
`timescale 1ns/100ps
`default_nettype none
interface pdec_sync_if #(parameter int W = 17) ();
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport top (output raw, input synced);
  modport sync (input raw, output synced);
endinterface
`default_nettype wire

/* sim/pdec_cpu_model.sv */
// Purpose: CPU core model that issues the power-down instruction
// Assumes: drives on the falling edge of clk
// Notes: qualifiers are set with the one-cycle pulse; only the write flag is cleared after it
`timescale 1ns/100ps
`default_nettype none
module pdec_cpu_model (
  // Clock
  input wire logic clk,
  // Instruction side
  output logic power_down_instruction,
  output logic prev_ext_write,
  output logic next_code_external
);
  // Idle core at time zero
  initial begin
    power_down_instruction = 1'b0;
    prev_ext_write = 1'b0;
    next_code_external = 1'b0;
  end

  // One pulse; qualifiers come from the caller
  task automatic issue(input logic wr, input logic ext);
    @(negedge clk);
    prev_ext_write = wr;
    next_code_external = ext;
    power_down_instruction = 1'b1;
    @(negedge clk);
    power_down_instruction = 1'b0;
    prev_ext_write = 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Purpose: self-checking bench for the power-down entry control block
// Assumes: inputs change on the falling edge
// Notes: pulses are counted, so a wrong pulse width shows as a wrong count
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pdec_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sel = 1'b0, mux = 1'b0, mttc = 1'b1, nmi = 1'b1, ewake = 1'b0;
  logic wdo = 1'b0, wdd = 1'b0;
  logic [15:0] wp = 16'h0000, wen = 16'h0028, wpol = 16'hffdf;
  wire pdi, pew, nce;
  wire pda, qia, fs, isb, etb, pr, wrr, ign;
  int n_mismatch = 0, n_compared = 0, n_ign = 0, n_wdr = 0, e_ign = 0;
  localparam logic [5:0] RUN = 6'h01, PD = 6'h28, QI = 6'h1f;

  // 25 MHz clock
  always #20 clk = ~clk;

  pdec_cpu_model i_pdec_cpu_model (.clk(clk), .power_down_instruction(pdi),
    .prev_ext_write(pew), .next_code_external(nce));
  pdec_entry_ctrl #(.WAKE_PINS(16)) i_pdec_entry_ctrl (.clk(clk), .reset(reset),
    .power_down_instruction(pdi), .prev_ext_write(pew), .next_code_external(nce),
    .wake_source_select(sel), .mux_bus_cfg(mux), .mem_tristate_wait_ctrl(mttc),
    .nmi_pin(nmi), .wake_pins(wp), .wake_pin_enable(wen), .wake_pin_active_high(wpol),
    .ext_interrupt_wake(ewake), .watchdog_overflow(wdo), .watchdog_disabled(wdd),
    .power_down_active(pda), .quasi_idle_active(qia), .fetch_stall(fs),
    .irq_service_block(isb), .event_transfer_channel_block(etb), .peripherals_run(pr),
    .watchdog_reset_req(wrr), .instr_ignored(ign));

  // Count pulse outputs edge by edge
  always @(posedge clk) begin
    if (ign === 1'b1) n_ign <= n_ign + 1;
    if (wrr === 1'b1) n_wdr <= n_wdr + 1;
  end

  function automatic logic [5:0] st();
    return {pda, qia, fs, isb, etb, pr};
  endfunction

  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded poll, then compare
  task automatic wait_st(input string what, input logic [5:0] exp);
    for (int i = 0; i < 5 && st() !== exp; i++) @(negedge clk);
    chk(what, exp, st());
  endtask

  // Pins get three cycles to pass the synchroniser
  task automatic pins(input logic n, input logic s, input logic [15:0] p);
    nmi = n;
    sel = s;
    wp = p;
    repeat (3) @(negedge clk);
  endtask

  // Code bits: write before, external code, mux bus, tristate wait bit
  task automatic try(input string what, input logic [3:0] c, input logic [5:0] exp);
    mux = c[1];
    mttc = c[0];
    i_pdec_cpu_model.issue(c[3], c[2]);
    wait_st(what, exp);
  endtask

  task automatic wd(input logic dis);
    wdd = dis;
    wdo = 1'b1;
    @(negedge clk);
    wdo = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_ignore();
    pins(1'b1, 1'b0, 16'h0000);
    i_pdec_cpu_model.issue(1'b0, 1'b0);
    i_pdec_cpu_model.issue(1'b0, 1'b0);
    e_ign += 2;
    repeat (3) @(negedge clk);
    chk("ignored count", e_ign[5:0], n_ign[5:0]);
    chk("run state", RUN, st());
  endtask

  task automatic t_enter();
    pins(1'b0, 1'b0, 16'h0000);
    i_pdec_cpu_model.issue(1'b0, 1'b0);
    wait_st("entered", PD);
    chk("not ignored", e_ign[5:0], n_ign[5:0]);
    ewake = 1'b1;
    wait_st("interrupt exit", RUN);
    ewake = 1'b0;
    i_pdec_cpu_model.issue(1'b0, 1'b0);
    wait_st("entered again", PD);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    wait_st("reset exit", RUN);
  endtask

  // Pin 3 active high, pin 5 active low, pin 0 not enabled
  task automatic t_wake();
    logic [15:0] p [3] = '{16'h0028, 16'h0000, 16'h0021};
    for (int i = 0; i < 3; i++) begin
      pins(1'b1, 1'b1, p[i]);
      i_pdec_cpu_model.issue(1'b0, 1'b0);
      e_ign += (i < 2);
      repeat (2) @(negedge clk);
      wait_st("wake pins", i < 2 ? RUN : PD);
      chk("wake ignored", e_ign[5:0], n_ign[5:0]);
    end
    ewake = 1'b1;
    wait_st("wake exit", RUN);
    ewake = 1'b0;
  endtask

  task automatic t_quasi();
    pins(1'b1, 1'b0, 16'h0000);
    try("mux tristate", 4'h6, QI);
    wd(1'b1);
    chk("watchdog off", QI, st());
    wd(1'b0);
    chk("watchdog resets", 6'h01, n_wdr[5:0]);
    wait_st("after watchdog", RUN);
    try("write before", 4'hd, QI);
    nmi = 1'b0;
    wait_st("pin low in quasi", PD);
    ewake = 1'b1;
    wait_st("exit", RUN);
    ewake = 1'b0;
    pins(1'b1, 1'b0, 16'h0000);
    try("tristate off", 4'h7, RUN);
    try("internal code", 4'h9, RUN);
    e_ign += 2;
    repeat (2) @(negedge clk);
    chk("quasi ignored", e_ign[5:0], n_ign[5:0]);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence with a 16-cycle reset
  initial begin
    repeat (15) @(negedge clk);
    chk("reset state", RUN, st());
    @(negedge clk);
    reset = 1'b0;
    t_ignore();
    t_enter();
    t_wake();
    t_quasi();
    finish_test();
  end

  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
